// file: logic/mwcp_consts.svh
// Constants for the memory write and code protection block.
// Overview of operation
// RL1: Low-voltage programming bit set makes the shared pin a reset; pin-enable bit ignored.
// RL2: While programming over the low-voltage interface, clearing that enable bit is refused.
// RL3: Storage area write-protect bit low blocks self-writes there, only when the area is enabled.
// RL4: Data EEPROM protect bit low blocks external EEPROM access; external reads return zero.
// RL5: The CPU always keeps full read and write access to the data EEPROM.
// RL6: Config write-protect bit low blocks self-writes to config words; high allows them.
// RL7: Boot block write-protect bit low blocks self-writes there, only when boot block enabled.
// RL8: Application write-protect bit low blocks self-writes to the application region.
// RL9: Boot block enable bit low makes a partition; high gives size zero.
// RL10: Boot size field is writable only while the boot block is disabled.
// RL11: Size codes 111..011 give 512, 1024, 2048, 4096, 8192 words from address zero.
// RL12: A boot size above half the user program memory is clamped to exactly half.
// RL13: Protection and enable bits are sticky; only a bulk erase returns them to one. Here the LVP bit is not sticky, and arst_n also reloads all ones.
// RL14: Code protect bit low blocks external program memory access; external reads return zero.
// RL15: CPU reads of program memory are never affected by code protection.
// RL16: CPU self-write permission depends on region write-protect bits only, never code protect.
// RL17: Program memory and EEPROM protection come from separate, independent bits.
// RL18: Four user ID words at 8000h-8003h are readable and writable in normal running.
// RL19: Bits 13 down to 1 of the code protection word always read as one.
// RL20: With low-voltage programming off, pin-enable bit chooses reset (1) or input (0).
// RL21: Every access carries a tag saying whether it comes from the CPU or the programmer.
// RL22: A blocked write changes no memory and starts no program or erase operation.
`ifndef MWCP_CONSTS_SVH
`define MWCP_CONSTS_SVH

`define MWCP_OFF_MEMCFG 2'h0
`define MWCP_OFF_CPCFG 2'h1
`define MWCP_OFF_STATUS 2'h2

`define MWCP_B_LVP 13
`define MWCP_B_STORAGE_AREA_WRITE_PROTECT_N 11
`define MWCP_B_EEPROM_WRITE_PROTECT_N 10
`define MWCP_B_CONFIG_WRITE_PROTECT_N 9
`define MWCP_B_BOOT_BLOCK_WRITE_PROTECT_N 8
`define MWCP_B_APP_BLOCK_WRITE_PROTECT_N 7
`define MWCP_B_STORAGE_AREA_ENABLE_N 4
`define MWCP_B_BOOT_BLOCK_ENABLE_N 3
`define MWCP_B_CP 0

`define MWCP_F_BOOT_BLOCK_SIZE_SEL 14'h0007
`define MWCP_F_LVP 14'h2000
`define MWCP_CFG_ERASED 14'h3FFF
`define MWCP_MEM_STICKY 14'h0F98
`define MWCP_MEM_WRMASK 14'h2F9F
`define MWCP_MEM_UNIMPL 14'h1060
`define MWCP_CP_STICKY 14'h0001
`define MWCP_CP_WRMASK 14'h0001
`define MWCP_CP_UNIMPL 14'h3FFE
`define MWCP_CP_ONES 13'h1FFF

`define MWCP_UID_BASE 16'h8000
`define MWCP_UID_LAST 16'h8003
`define MWCP_BB_MIN_WORDS 17'h00200
`define MWCP_BB_SEL_MIN 3'h7

`define MWCP_ST_PINRST 0
`define MWCP_ST_LVP 1
`define MWCP_ST_BBACT 2
`define MWCP_ST_BLK 3

`endif

// file: logic/mwcp_pkg.sv
// Types shared by the memory write and code protection block.
package mwcp_pkg;

	typedef struct packed {
		logic valid;
		logic ext;
		logic write;
		logic eeprom;
		logic [15:0] addr;
		logic [13:0] wdata;
	} mwcp_req_t;

	typedef struct packed {
		logic done;
		logic blocked;
		logic [13:0] rdata;
	} mwcp_rsp_t;

	typedef struct packed {
		logic [13:0] word;
	} mwcp_word_st_t;

	typedef struct packed {
		logic [3:0][13:0] uid;
		mwcp_rsp_t rsp;
		logic [13:0] reg_rdata;
		logic pin_reset;
		logic lvp_en;
		logic [16:0] bb_size;
		logic last_blocked;
	} mwcp_top_st_t;

endpackage : mwcp_pkg

// file: logic/mwcp_sticky_word.sv
// One configuration word with sticky protection bits and bulk erase.
`include "mwcp_consts.svh"

module mwcp_sticky_word #(
	parameter logic [13:0] STICKY = `MWCP_MEM_STICKY,
	parameter logic [13:0] WRMASK = `MWCP_MEM_WRMASK,
	parameter logic [13:0] UNIMPL = `MWCP_MEM_UNIMPL
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic erase,
	input wire logic wr,
	input wire logic [13:0] wr_data,
	input wire logic [13:0] wr_allow,
	output logic [13:0] value
);

	mwcp_pkg::mwcp_word_st_t st_r;
	mwcp_pkg::mwcp_word_st_t st_nxt;
	logic [13:0] m;

	if ((STICKY & ~WRMASK) != 14'h0000) begin : g_bad_mask
		$error("Sticky bits must be writable");
	end

	assign m = WRMASK & wr_allow;

	always_comb begin
		st_nxt = st_r;
		if (erase) begin
			st_nxt.word = `MWCP_CFG_ERASED; // RL13
		end else if (wr) begin
			st_nxt.word = ((st_r.word & ~m) | (wr_data & m)) & (st_r.word | ~STICKY); // RL13
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= '{word: `MWCP_CFG_ERASED};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign value = st_r.word | UNIMPL;

	sticky_no_rise_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL13
		!$past(erase) |-> ((value & STICKY & ~$past(value)) == 14'h0000))
		else $error("Sticky bit returned to one without bulk erase");

endmodule : mwcp_sticky_word

// file: logic/mwcp_boot_size.sv
// Boot block size decode with clamping to half of program memory.
`include "mwcp_consts.svh"

module mwcp_boot_size #(
	parameter int PROG_WORDS = 16384
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic boot_block_enable_n_n,
	input wire logic [2:0] sel,
	output logic [16:0] size
);

	localparam logic [16:0] HALF = 17'(PROG_WORDS / 2);
	logic [16:0] raw;

	// Each step down in the code doubles the size, starting at 512 words.
	assign raw = `MWCP_BB_MIN_WORDS << (`MWCP_BB_SEL_MIN - sel); // RL11
	assign size = boot_block_enable_n_n ? 17'h00000 : ((raw > HALF) ? HALF : raw); // RL9 RL12

	bb_clamp_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL12
		!boot_block_enable_n_n |-> (size <= HALF && size != 17'h00000))
		else $error("Boot block size exceeds half of program memory");

	bb_off_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL9
		boot_block_enable_n_n |-> size == 17'h00000)
		else $error("Disabled boot block has nonzero size");

endmodule : mwcp_boot_size

// file: logic/mwcp_top.sv
// Memory write protection and code protection top level.
`include "mwcp_consts.svh"

module mwcp_top #(
	parameter int PROG_WORDS = 16384,
	parameter int SAF_WORDS = 128
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [1:0] reg_addr,
	input wire logic [13:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [13:0] reg_rdata,
	input wire logic bulk_erase,
	input wire logic lvp_prog_active,
	input wire logic reset_pin_enable,
	input wire mwcp_pkg::mwcp_req_t acc_req,
	input wire logic [13:0] mem_rdata,
	input wire logic [13:0] eeprom_rdata,
	output logic mem_wr_go,
	output mwcp_pkg::mwcp_rsp_t acc_rsp,
	output logic reset_pin_is_reset,
	output logic low_voltage_prog_enable,
	output logic [16:0] boot_block_size
);

	// ************************************************************
	// Parameter checks
	// ************************************************************

	if (PROG_WORDS < 1024 || PROG_WORDS > 32768 ||
		(PROG_WORDS & (PROG_WORDS - 1)) != 0) begin : g_bad_prog
		$error("PROG_WORDS must be a power of two from 1024 to 32768");
	end

	if (SAF_WORDS < 1 || SAF_WORDS >= PROG_WORDS / 2) begin : g_bad_saf
		$error("SAF_WORDS must be below half of PROG_WORDS");
	end

	localparam logic [16:0] PROG_LIM = 17'(PROG_WORDS);
	localparam logic [16:0] SAF_BASE = 17'(PROG_WORDS - SAF_WORDS);

	mwcp_pkg::mwcp_top_st_t st_r;
	mwcp_pkg::mwcp_top_st_t st_nxt;

	// ************************************************************
	// Configuration words
	// ************************************************************

	logic [13:0] memcfg;
	logic [13:0] cpcfg;
	logic memcfg_wr;
	logic cpcfg_wr;
	logic [13:0] memcfg_allow;
	logic [13:0] cpcfg_allow;
	logic cfg_unlocked;

	assign memcfg_wr = reg_wr && reg_addr == `MWCP_OFF_MEMCFG;
	assign cpcfg_wr = reg_wr && reg_addr == `MWCP_OFF_CPCFG;

	// With the config lock set every self-write to either word is dropped.
	assign cfg_unlocked = memcfg[`MWCP_B_CONFIG_WRITE_PROTECT_N]; // RL6

	always_comb begin
		memcfg_allow = cfg_unlocked ? `MWCP_CFG_ERASED : 14'h0000; // RL6
		if (lvp_prog_active) begin
			memcfg_allow = memcfg_allow & ~`MWCP_F_LVP; // RL2
		end
		if (!memcfg[`MWCP_B_BOOT_BLOCK_ENABLE_N]) begin
			memcfg_allow = memcfg_allow & ~`MWCP_F_BOOT_BLOCK_SIZE_SEL; // RL10
		end
		cpcfg_allow = cfg_unlocked ? `MWCP_CFG_ERASED : 14'h0000; // RL6
	end

	mwcp_sticky_word #(
		.STICKY(`MWCP_MEM_STICKY),
		.WRMASK(`MWCP_MEM_WRMASK),
		.UNIMPL(`MWCP_MEM_UNIMPL)
	) u_memcfg (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.erase(bulk_erase),
		.wr(memcfg_wr),
		.wr_data(reg_wdata),
		.wr_allow(memcfg_allow),
		.value(memcfg)
	);

	mwcp_sticky_word #(
		.STICKY(`MWCP_CP_STICKY),
		.WRMASK(`MWCP_CP_WRMASK),
		.UNIMPL(`MWCP_CP_UNIMPL)
	) u_cpcfg (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.erase(bulk_erase),
		.wr(cpcfg_wr),
		.wr_data(reg_wdata),
		.wr_allow(cpcfg_allow),
		.value(cpcfg) // RL19
	);

	logic [16:0] bb_size_c;

	mwcp_boot_size #(
		.PROG_WORDS(PROG_WORDS)
	) u_boot_block_size_sel (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.boot_block_enable_n_n(memcfg[`MWCP_B_BOOT_BLOCK_ENABLE_N]),
		.sel(memcfg[2:0]),
		.size(bb_size_c)
	);

	// ************************************************************
	// Access decode
	// ************************************************************

	logic [16:0] addr_x;
	logic in_pm;
	logic in_uid;
	logic in_bb;
	logic in_saf;
	logic in_app;
	logic mapped;
	logic self_blk;
	logic ext_blk;
	logic blocked;
	logic [1:0] uid_idx;
	logic [13:0] rd_src;

	assign addr_x = {1'b0, acc_req.addr};
	assign uid_idx = acc_req.addr[1:0];
	assign in_pm = !acc_req.eeprom && addr_x < PROG_LIM;
	assign in_uid = !acc_req.eeprom && acc_req.addr >= `MWCP_UID_BASE &&
		acc_req.addr <= `MWCP_UID_LAST;
	assign mapped = acc_req.eeprom || in_pm || in_uid;

	// Regions: boot block from zero, storage area at the top, the rest is application.
	assign in_bb = in_pm && addr_x < bb_size_c; // RL7
	assign in_saf = in_pm && !memcfg[`MWCP_B_STORAGE_AREA_ENABLE_N] && addr_x >= SAF_BASE; // RL3
	assign in_app = in_pm && !in_bb && !in_saf;

	// Self-writes look only at region locks; the code protect bit is not consulted.
	assign self_blk = (in_bb && !memcfg[`MWCP_B_BOOT_BLOCK_WRITE_PROTECT_N]) || // RL7 RL16
		(in_saf && !memcfg[`MWCP_B_STORAGE_AREA_WRITE_PROTECT_N]) || // RL3
		(in_app && !memcfg[`MWCP_B_APP_BLOCK_WRITE_PROTECT_N]); // RL8

	// External access is gated by two separate bits, one per memory.
	assign ext_blk = acc_req.eeprom ? !memcfg[`MWCP_B_EEPROM_WRITE_PROTECT_N] : // RL4 RL17
		(in_pm && !cpcfg[`MWCP_B_CP]); // RL14 RL17

	// CPU reads and CPU EEPROM writes are never blocked by a mapped address.
	assign blocked = !mapped || (acc_req.ext ? ext_blk : // RL21
		(acc_req.write && !acc_req.eeprom && self_blk)); // RL5 RL15 RL16

	assign mem_wr_go = acc_req.valid && acc_req.write && !blocked && !in_uid; // RL22

	always_comb begin
		if (in_uid) begin
			rd_src = st_r.uid[uid_idx]; // RL18
		end else if (acc_req.eeprom) begin
			rd_src = eeprom_rdata;
		end else begin
			rd_src = mem_rdata;
		end
	end

	// ************************************************************
	// State update
	// ************************************************************

	always_comb begin
		st_nxt = st_r;
		st_nxt.rsp.done = acc_req.valid;
		st_nxt.rsp.blocked = acc_req.valid && blocked;
		// Refused reads answer with zeros so nothing leaks to the programmer.
		st_nxt.rsp.rdata = (acc_req.valid && !blocked) ? rd_src : 14'h0000; // RL4 RL14
		if (acc_req.valid) begin
			st_nxt.last_blocked = blocked;
		end
		if (bulk_erase) begin
			st_nxt.uid = {4{`MWCP_CFG_ERASED}};
		end else if (acc_req.valid && acc_req.write && in_uid && !blocked) begin
			st_nxt.uid[uid_idx] = acc_req.wdata; // RL18
		end
		st_nxt.lvp_en = memcfg[`MWCP_B_LVP];
		st_nxt.pin_reset = memcfg[`MWCP_B_LVP] || reset_pin_enable; // RL1 RL20
		st_nxt.bb_size = bb_size_c;
		st_nxt.reg_rdata = 14'h0000;
		if (reg_rd) begin
			case (reg_addr)
				`MWCP_OFF_MEMCFG: begin
					st_nxt.reg_rdata = memcfg;
				end
				`MWCP_OFF_CPCFG: begin
					st_nxt.reg_rdata = cpcfg; // RL19
				end
				`MWCP_OFF_STATUS: begin
					st_nxt.reg_rdata[`MWCP_ST_PINRST] = st_r.pin_reset;
					st_nxt.reg_rdata[`MWCP_ST_LVP] = st_r.lvp_en;
					st_nxt.reg_rdata[`MWCP_ST_BBACT] = !memcfg[`MWCP_B_BOOT_BLOCK_ENABLE_N];
					st_nxt.reg_rdata[`MWCP_ST_BLK] = st_r.last_blocked;
				end
				default: begin
					st_nxt.reg_rdata = 14'h0000;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= '{
				uid: {4{`MWCP_CFG_ERASED}},
				rsp: '{done: 1'b0, blocked: 1'b0, rdata: 14'h0000},
				reg_rdata: 14'h0000,
				pin_reset: 1'b1,
				lvp_en: 1'b1,
				bb_size: 17'h00000,
				last_blocked: 1'b0
			};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata = st_r.reg_rdata;
	assign acc_rsp = st_r.rsp;
	assign reset_pin_is_reset = st_r.pin_reset;
	assign low_voltage_prog_enable = st_r.lvp_en;
	assign boot_block_size = st_r.bb_size;

	// ************************************************************
	// Assertions
	// ************************************************************

	sequence s_ext_pm;
		acc_req.valid && acc_req.ext && in_pm && !cpcfg[`MWCP_B_CP];
	endsequence

	sequence s_ext_ee;
		acc_req.valid && acc_req.ext && acc_req.eeprom && !memcfg[`MWCP_B_EEPROM_WRITE_PROTECT_N];
	endsequence

	sequence s_uid_wr;
		acc_req.valid && acc_req.write && in_uid && !bulk_erase;
	endsequence

	sequence s_zero_answer;
		acc_rsp.done && acc_rsp.blocked && acc_rsp.rdata == 14'h0000;
	endsequence

	code_protect_ext_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL14
		s_ext_pm |-> !mem_wr_go ##1 s_zero_answer)
		else $error("External program memory access passed under code protection");

	eeprom_protect_ext_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL4
		s_ext_ee |-> !mem_wr_go ##1 s_zero_answer)
		else $error("External EEPROM access passed under protection");

	cpu_eeprom_free_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL5
		acc_req.valid && !acc_req.ext && acc_req.eeprom |=> acc_rsp.done && !acc_rsp.blocked)
		else $error("CPU EEPROM access was blocked");

	cpu_pm_read_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL15
		acc_req.valid && !acc_req.ext && !acc_req.write && in_pm
		|=> !acc_rsp.blocked && acc_rsp.rdata == $past(mem_rdata))
		else $error("CPU program memory read was altered");

	boot_write_block_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL7
		acc_req.valid && !acc_req.ext && acc_req.write && in_bb && !memcfg[`MWCP_B_BOOT_BLOCK_WRITE_PROTECT_N]
		|-> !mem_wr_go ##1 acc_rsp.blocked)
		else $error("Self-write reached a locked boot block");

	app_write_block_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL8 RL22
		acc_req.valid && !acc_req.ext && acc_req.write && in_app && !memcfg[`MWCP_B_APP_BLOCK_WRITE_PROTECT_N]
		|-> !mem_wr_go)
		else $error("Self-write reached a locked application block");

	saf_write_block_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL3
		acc_req.valid && !acc_req.ext && acc_req.write && in_saf &&
		!memcfg[`MWCP_B_STORAGE_AREA_WRITE_PROTECT_N] |-> !mem_wr_go)
		else $error("Self-write reached a locked storage area");

	cfg_lock_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL6
		reg_wr && !memcfg[`MWCP_B_CONFIG_WRITE_PROTECT_N] && !bulk_erase |=> $stable(memcfg) && $stable(cpcfg))
		else $error("Config word changed while write-protected");

	lvp_keep_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL2
		memcfg_wr && lvp_prog_active && memcfg[`MWCP_B_LVP] && !bulk_erase
		|=> memcfg[`MWCP_B_LVP])
		else $error("Low-voltage enable cleared during low-voltage programming");

	bb_size_lock_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL10
		memcfg_wr && !memcfg[`MWCP_B_BOOT_BLOCK_ENABLE_N] && !bulk_erase |=> $stable(memcfg[2:0]))
		else $error("Boot size changed while boot block enabled");

	pin_func_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL1 RL20
		##1 reset_pin_is_reset == ($past(memcfg[`MWCP_B_LVP]) || $past(reset_pin_enable)))
		else $error("Reset pin function does not follow configuration");

	uid_store_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL18
		s_uid_wr |=> st_r.uid[$past(uid_idx)] == $past(acc_req.wdata))
		else $error("User ID word did not store the written value");

	cp_ones_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL19
		reg_rd && reg_addr == `MWCP_OFF_CPCFG |=> reg_rdata[13:1] == `MWCP_CP_ONES)
		else $error("Unimplemented code protect bits did not read as one");

endmodule : mwcp_top

// file: tb/mwcp_mem_model.sv
// Far-side memory model: program memory and data EEPROM with same-cycle read data.
module mwcp_mem_model (
	input wire logic sys_clk,
	input wire mwcp_pkg::mwcp_req_t acc_req,
	input wire logic mem_wr_go,
	output logic [13:0] mem_rdata,
	output logic [13:0] eeprom_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [13:0] pm [0:16383];
	logic [13:0] ee [0:255];
	initial begin
		for (int i = 0; i < 16384; i++) begin
			pm[i] = 14'(i * 5 + 3);
		end
		for (int i = 0; i < 256; i++) begin
			ee[i] = 14'(i) ^ 14'h2A5A;
		end
	end
	// An idle port shows inverted data so stale values never pass for a fresh answer.
	always_comb begin
		mem_rdata = acc_req.valid ? pm[acc_req.addr[13:0]] : ~pm[acc_req.addr[13:0]];
		eeprom_rdata = acc_req.valid ? ee[acc_req.addr[7:0]] : ~ee[acc_req.addr[7:0]];
	end
	always @(posedge sys_clk) begin
		if (mem_wr_go && acc_req.eeprom) begin
			ee[acc_req.addr[7:0]] <= acc_req.wdata;
		end else if (mem_wr_go) begin
			pm[acc_req.addr[13:0]] <= acc_req.wdata;
		end
	end
endmodule : mwcp_mem_model

// file: tb/test_memory_write_code_protect.sv
// Self-checking testbench for the memory write and code protection block.
module test_memory_write_code_protect;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PW = 16384;
	localparam int SW = 128;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [1:0] reg_addr = 2'h0;
	logic [13:0] reg_wdata = 14'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic bulk_erase = 1'b0;
	logic lvp_prog_active = 1'b0;
	logic reset_pin_enable = 1'b1;
	mwcp_pkg::mwcp_req_t acc_req = '0;
	logic [13:0] reg_rdata, mem_rdata, eeprom_rdata;
	logic mem_wr_go, reset_pin_is_reset, low_voltage_prog_enable;
	mwcp_pkg::mwcp_rsp_t acc_rsp;
	logic [16:0] boot_block_size;
	logic [13:0] w0 = 14'h3FFF;
	logic [13:0] w1 = 14'h3FFF;
	logic [13:0] uid_e [4] = '{4{14'h3FFF}};
	logic [15:0] lfsr = 16'h0040;
	int num_errors = 0;
	int checks_done = 0;

	always #25 sys_clk = ~sys_clk;

	mwcp_top #(.PROG_WORDS(PW), .SAF_WORDS(SW)) u_dut (.sys_clk(sys_clk), .arst_n(arst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .bulk_erase(bulk_erase), .lvp_prog_active(lvp_prog_active),
		.reset_pin_enable(reset_pin_enable), .acc_req(acc_req), .mem_rdata(mem_rdata),
		.eeprom_rdata(eeprom_rdata), .mem_wr_go(mem_wr_go), .acc_rsp(acc_rsp),
		.reset_pin_is_reset(reset_pin_is_reset),
		.low_voltage_prog_enable(low_voltage_prog_enable), .boot_block_size(boot_block_size));

	mwcp_mem_model u_mem (.sys_clk(sys_clk), .acc_req(acc_req), .mem_wr_go(mem_wr_go),
		.mem_rdata(mem_rdata), .eeprom_rdata(eeprom_rdata));

	// ****************************************
	// Expectation functions
	// ****************************************
	function automatic logic [15:0] rnd();
		lfsr = {1'b0, lfsr[15:1]} ^ (lfsr[0] ? 16'hB400 : 16'h0000);
		return lfsr;
	endfunction : rnd

	function automatic logic [16:0] bb_exp(input logic [13:0] w);
		logic [16:0] s;
		s = 17'h00200 << (3'h7 - w[2:0]);
		if (s > 17'(PW / 2)) begin
			s = 17'(PW / 2);
		end
		return w[3] ? 17'h00000 : s;
	endfunction : bb_exp

	function automatic logic is_uid(input mwcp_pkg::mwcp_req_t r);
		return !r.eeprom && r.addr >= 16'h8000 && r.addr <= 16'h8003;
	endfunction : is_uid

	function automatic logic blk_exp(input mwcp_pkg::mwcp_req_t r);
		if (is_uid(r)) return 1'b0;
		if (r.ext) return r.eeprom ? !w0[10] : !w1[0];
		if (r.eeprom || !r.write) return 1'b0;
		if (17'(r.addr) < bb_exp(w0)) return !w0[8];
		if (!w0[4] && r.addr >= 16'(PW - SW)) return !w0[11];
		return !w0[7];
	endfunction : blk_exp

	// ****************************************
	// Drivers and checks
	// ****************************************
	task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic reg_rd_t(input logic [1:0] a, input logic [13:0] e, input string nm);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		chk(nm, 17'(e), 17'(reg_rdata));
	endtask : reg_rd_t

	// Word 0 refusals are applied per bit; the size field follows the enable bit before the write.
	task automatic cfg_wr(input logic [1:0] a, input logic [13:0] d);
		logic [13:0] m;
		logic [13:0] nv;
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		m = 14'h2F9F;
		if (lvp_prog_active) m[13] = 1'b0;
		if (!w0[3]) m[2:0] = 3'h0;
		nv = (w0 & ~m) | (d & m);
		nv = (nv & ~14'h0F98) | (nv & w0 & 14'h0F98);
		if (w0[9] && a == 2'h1) w1 = 14'h3FFE | (w1 & d);
		if (w0[9] && a == 2'h0) w0 = nv | 14'h1060;
	endtask : cfg_wr

	task automatic erase();
		@(posedge sys_clk);
		bulk_erase <= 1'b1;
		@(posedge sys_clk);
		bulk_erase <= 1'b0;
		w0 = 14'h3FFF;
		w1 = 14'h3FFF;
		uid_e = '{4{14'h3FFF}};
	endtask : erase

	task automatic outs_chk();
		repeat (3) @(posedge sys_clk);
		@(negedge sys_clk);
		chk("lvp_out", 17'(w0[13]), 17'(low_voltage_prog_enable));
		chk("pin_reset", 17'(w0[13] | reset_pin_enable), 17'(reset_pin_is_reset));
		chk("bb_size", bb_exp(w0), boot_block_size);
	endtask : outs_chk

	task automatic access(input mwcp_pkg::mwcp_req_t r);
		logic b;
		logic u;
		logic [13:0] d;
		b = blk_exp(r);
		u = is_uid(r);
		@(posedge sys_clk);
		acc_req <= r;
		@(negedge sys_clk);
		d = u ? uid_e[r.addr[1:0]] : (r.eeprom ? eeprom_rdata : mem_rdata);
		chk("mem_wr_go", 17'(r.write && !b && !u), 17'(mem_wr_go));
		if (r.write && u) uid_e[r.addr[1:0]] = r.wdata;
		@(posedge sys_clk);
		acc_req <= '0;
		@(negedge sys_clk);
		chk("acc_done", 17'h00001, 17'(acc_rsp.done));
		chk("acc_blocked", 17'(b), 17'(acc_rsp.blocked));
		if (!r.write) chk("acc_rdata", b ? 17'h0 : 17'(d), 17'(acc_rsp.rdata));
	endtask : access

	task automatic print_verdict();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : print_verdict

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (90000) @(posedge sys_clk);
		num_errors++;
		print_verdict();
	end

	initial begin
		mwcp_pkg::mwcp_req_t r;
		logic [15:0] v;
		repeat (6) @(posedge sys_clk);
		arst_n <= 1'b1;
		reg_rd_t(2'h0, 14'h3FFF, "word0_reset");
		reg_rd_t(2'h1, 14'h3FFF, "word1_reset");
		reg_rd_t(2'h3, 14'h0000, "unmapped");
		@(posedge sys_clk);
		lvp_prog_active <= 1'b1;
		cfg_wr(2'h0, 14'h1FFF);
		reg_rd_t(2'h0, w0, "lvp_hold");
		outs_chk();
		@(posedge sys_clk);
		lvp_prog_active <= 1'b0;
		reset_pin_enable <= 1'b0;
		cfg_wr(2'h0, 14'h1FFF);
		outs_chk();
		cfg_wr(2'h0, 14'h1F7F);
		cfg_wr(2'h0, 14'h1FFF);
		reg_rd_t(2'h0, w0, "sticky");
		cfg_wr(2'h0, 14'h1DFF);
		cfg_wr(2'h0, 14'h0000);
		cfg_wr(2'h1, 14'h0000);
		reg_rd_t(2'h0, w0, "cfg_lock0");
		reg_rd_t(2'h1, w1, "cfg_lock1");
		for (int s = 0; s < 8; s++) begin
			erase();
			cfg_wr(2'h0, 14'h3FF8 | 14'(s));
			outs_chk();
			cfg_wr(2'h0, 14'h3FF0 | 14'(s));
			cfg_wr(2'h0, 14'h3FF0 | 14'(~s & 7));
			reg_rd_t(2'h0, w0, "bb_word");
			outs_chk();
		end
		for (int n = 0; n < 40; n++) begin
			erase();
			v = rnd();
			@(posedge sys_clk);
			reset_pin_enable <= v[0];
			cfg_wr(2'h1, v[13:0] ^ 14'h0002);
			v = rnd();
			cfg_wr(2'h0, v[13:0] | 14'h0200);
			v = rnd();
			if (n[0]) cfg_wr(2'h0, {2'h3, v[11:0]} ^ 14'h0200);
			reg_rd_t(2'h1, w1, "word1");
			outs_chk();
			for (int k = 0; k < 16; k++) begin
				v = rnd();
				r = '0;
				r.valid = 1'b1;
				r.ext = v[15];
				r.write = v[14];
				r.eeprom = v[13] & v[12];
				r.wdata = v[13:0] ^ 14'h155A;
				r.addr = v[11] ? {7'h00, v[8:0]} : (v[10] ? {9'h07F, v[6:0]} : {2'h0, v[13:0]});
				if (r.eeprom) r.addr = {8'h00, v[7:0]};
				if (k >= 12) r.addr = 16'h8000 | 16'(v[1:0]);
				if (k >= 12) r.ext = 1'b0;
				if (k >= 12) r.eeprom = 1'b0;
				access(r);
			end
		end
		print_verdict();
	end
endmodule : test_memory_write_code_protect
